// ### mgmt_cpu_model.sv
// model of the processor core that answers management interrupts
// assumes an active-low request sampled on clk_i, level acknowledge
`timescale 1ns/1ps
module mgmt_cpu_model #(
  parameter int ACK_DLY = 40
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // interrupt link
  input wire logic irq_n_i,
  output logic ack_o
);
  logic [7:0] wait_ff;
  // ********************************************************
  // handshake
  // ********************************************************
  // enter management mode some cycles after the request, leave in the
  // cycle after the request drops, without looking at the causes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff <= 8'h00;
      ack_o <= 1'b0;
    end else if (!irq_n_i) begin
      if (wait_ff == 8'(ACK_DLY)) begin
        ack_o <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 8'h01;
      end
    end else begin
      wait_ff <= 8'h00;
      ack_o <= 1'b0;
    end
  end
endmodule // mgmt_cpu_model

// ### mgmt_event_pkg.sv
// constants and carriers for the management event and idle timer block
// assumes a 16-bit indexed register port and one 200 MHz system clock
package mgmt_event_pkg;

  // ********************************************************
  // register port
  // ********************************************************
  localparam logic [15:0] INDEX_PORT_ADDR = 16'h0024;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h0026;
  localparam int INDEX_W = 6;
  localparam logic [5:0] IDX_IDLE_TIMER = 6'h0b;
  localparam logic [5:0] IDX_EVENT_CTRL = 6'h0c;
  localparam logic [5:0] INDEX_RESET = 6'h00;

  // ********************************************************
  // idle timer layout
  // ********************************************************
  localparam int COUNT_W = 12;
  localparam int PRE_BIT = 15;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [5:0] PRESCALE_ONES = 6'h3f;

  // ********************************************************
  // event control/status bit positions
  // ********************************************************
  localparam int B_EXT_EN = 0;
  localparam int B_ACT_EN = 1;
  localparam int B_TIM_EN = 2;
  localparam int B_HALT_EN = 3;
  localparam int B_SW_TRIG = 4;
  localparam int B_GLOBAL_EN = 5;
  localparam int B_PCS_EN = 6;
  localparam int B_LOW_MAP = 7;
  localparam int B_TOP_MAP = 8;
  localparam int B_EXT_FLAG = 9;
  localparam int B_TIM_FLAG = 10;
  localparam int B_HALT_FLAG = 12;

  // ********************************************************
  // low management region 0xa0000-0xbffff: address bits 19:17
  // ********************************************************
  localparam logic [2:0] LOW_REGION_TAG = 3'h5;

  // software control bits of the event register
  typedef struct packed {
    logic top_region_map_enable;
    logic low_region_map_enable;
    logic chip_select_activity_enable;
    logic global_event_enable;
    logic software_event_trigger;
    logic halt_event_enable;
    logic timer_count_enable;
    logic activity_reload_enable;
    logic external_event_enable;
  } event_ctrl_t;

  localparam event_ctrl_t EVENT_CTRL_RESET = '0;

  // sticky source status flags
  typedef struct packed {
    logic halt_state_flag;
    logic timer_expired_flag;
    logic external_event_flag;
  } event_flags_t;

  localparam event_flags_t EVENT_FLAGS_RESET = '0;

endpackage

// ### mgmt_event_timer.sv
// management interrupt event logic with programmable idle timer
// assumes synchronous inputs, one-cycle 1024 Hz tick, 16-bit io port
`timescale 1ns/1ps
module mgmt_event_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // indexed register port
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  // event sources
  input wire logic tick_1024hz_i,
  input wire logic external_event_input_n_i,
  input wire logic chip_select_activity_i,
  input wire logic halt_cycle_i,
  // processor handshake
  input wire logic mgmt_mode_acknowledge_i,
  output logic mgmt_interrupt_output_n_o,
  // memory remap
  input wire logic [19:0] mem_addr_i,
  output logic low_region_dram_o,
  output logic top_region_allow_o
);

  // ********************************************************
  // functions
  // ********************************************************

  // sticky flag: a set in the clear cycle wins
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic wr, input logic wbit);
    sticky = set | (cur & ~(wr & ~wbit));
  endfunction

  // address falls in the low management region
  function automatic logic in_low_region(input logic [19:0] a);
    in_low_region = (a[19:17] == mgmt_event_pkg::LOW_REGION_TAG);
  endfunction

  // ********************************************************
  // state
  // ********************************************************
  logic [5:0] index_ff;
  logic prescale_sel_ff;
  logic [11:0] reload_latch_ff;
  logic [11:0] count_ff;
  logic [5:0] prescaler_ff;
  mgmt_event_pkg::event_ctrl_t ctrl_ff;
  mgmt_event_pkg::event_flags_t flags_ff;
  mgmt_event_pkg::event_flags_t nxt_flags;
  logic [15:0] nxt_rdata;

  // ********************************************************
  // decode
  // ********************************************************
  logic data_hit;
  logic wr_timer;
  logic wr_event;
  logic ext_asserted;
  logic tick_16hz;
  logic dec_now;
  logic reload_now;
  logic expire_now;
  logic ext_set;
  logic halt_set;
  logic tim_set;

  // either byte of the data port writes the whole word
  assign data_hit = (io_addr_i[15:1] ==
                     mgmt_event_pkg::DATA_PORT_ADDR[15:1]);
  assign wr_timer = io_wr_i & data_hit &
                    (index_ff == mgmt_event_pkg::IDX_IDLE_TIMER);
  assign wr_event = io_wr_i & data_hit &
                    (index_ff == mgmt_event_pkg::IDX_EVENT_CTRL);
  assign ext_asserted = ~external_event_input_n_i;

  // tick selection and counter control
  assign tick_16hz = tick_1024hz_i & (prescaler_ff == 6'h00);
  assign dec_now = ctrl_ff.timer_count_enable & (count_ff != 12'h000) &
                   (prescale_sel_ff ? tick_16hz : tick_1024hz_i);
  assign reload_now =
      (ext_asserted & ctrl_ff.activity_reload_enable) |
      (chip_select_activity_i & ctrl_ff.chip_select_activity_enable) |
      ((count_ff == 12'h000) & mgmt_mode_acknowledge_i);
  // a write or reload in the expiry cycle keeps the counter off zero
  assign expire_now = dec_now & (count_ff == 12'h001) &
                      ~wr_timer & ~reload_now;

  // source events, gated by their own and the global enable
  assign tim_set = expire_now & ctrl_ff.global_event_enable;
  assign ext_set = ext_asserted & ctrl_ff.external_event_enable &
                   ctrl_ff.global_event_enable;
  assign halt_set = halt_cycle_i & ctrl_ff.halt_event_enable &
                    ctrl_ff.global_event_enable;

  // ********************************************************
  // register port
  // ********************************************************

  // index register keeps the low six bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_ff <= mgmt_event_pkg::INDEX_RESET;
    end else if (io_wr_i && io_addr_i == mgmt_event_pkg::INDEX_PORT_ADDR)
    begin
      index_ff <= io_wdata_i[5:0];
    end
  end

  // read word of the selected register, unmapped reads zero
  always_comb begin
    nxt_rdata = 16'h0000;
    case (index_ff)
      mgmt_event_pkg::IDX_IDLE_TIMER: begin
        nxt_rdata[mgmt_event_pkg::PRE_BIT] = prescale_sel_ff;
        nxt_rdata[11:0] = count_ff;
      end
      mgmt_event_pkg::IDX_EVENT_CTRL: begin
        nxt_rdata[8:0] = ctrl_ff;
        nxt_rdata[mgmt_event_pkg::B_EXT_FLAG] =
            flags_ff.external_event_flag;
        nxt_rdata[mgmt_event_pkg::B_TIM_FLAG] =
            flags_ff.timer_expired_flag;
        nxt_rdata[mgmt_event_pkg::B_HALT_FLAG] = flags_ff.halt_state_flag;
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  // read data is captured one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i && data_hit) begin
      io_rdata_o <= nxt_rdata;
    end
  end

  // ********************************************************
  // idle timer
  // ********************************************************

  // prescale select and reload latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_sel_ff <= 1'b0;
      reload_latch_ff <= mgmt_event_pkg::COUNT_RESET;
    end else if (wr_timer) begin
      prescale_sel_ff <= io_wdata_i[mgmt_event_pkg::PRE_BIT];
      reload_latch_ff <= io_wdata_i[11:0];
    end
  end

  // down-counting prescaler divides 1024 Hz by 64
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_timer) begin
      prescaler_ff <= mgmt_event_pkg::PRESCALE_ONES;
    end else if (tick_1024hz_i) begin
      prescaler_ff <= prescaler_ff - 6'h01;
    end
  end

  // counter: write, then reload, then decrement; holds at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= mgmt_event_pkg::COUNT_RESET;
    end else if (wr_timer) begin
      count_ff <= io_wdata_i[11:0];
    end else if (reload_now) begin
      count_ff <= reload_latch_ff;
    end else if (dec_now) begin
      count_ff <= count_ff - 12'h001;
    end
  end

  // ********************************************************
  // control and status
  // ********************************************************

  // control bits, all clear at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= mgmt_event_pkg::EVENT_CTRL_RESET;
    end else if (wr_event) begin
      ctrl_ff <= io_wdata_i[8:0];
    end
  end

  // flags: hardware set beats a written zero, a written one keeps
  always_comb begin
    nxt_flags.external_event_flag = sticky(flags_ff.external_event_flag,
        ext_set, wr_event, io_wdata_i[mgmt_event_pkg::B_EXT_FLAG]);
    nxt_flags.timer_expired_flag = sticky(flags_ff.timer_expired_flag,
        tim_set, wr_event, io_wdata_i[mgmt_event_pkg::B_TIM_FLAG]);
    nxt_flags.halt_state_flag = sticky(flags_ff.halt_state_flag,
        halt_set, wr_event, io_wdata_i[mgmt_event_pkg::B_HALT_FLAG]);
  end

  // sticky status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_ff <= mgmt_event_pkg::EVENT_FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ********************************************************
  // processor interrupt and memory remap
  // ********************************************************

  // active low interrupt while any pending source and global enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_interrupt_output_n_o <= 1'b1;
    end else begin
      mgmt_interrupt_output_n_o <= ~(ctrl_ff.global_event_enable &
          ((|flags_ff) | ctrl_ff.software_event_trigger));
    end
  end

  // region steering under management acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_region_dram_o <= 1'b0;
      top_region_allow_o <= 1'b1;
    end else begin
      low_region_dram_o <= ctrl_ff.low_region_map_enable &
          mgmt_mode_acknowledge_i & in_low_region(mem_addr_i);
      top_region_allow_o <= ~ctrl_ff.top_region_map_enable |
          mgmt_mode_acknowledge_i;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************

  AST_WRITE_LOADS_COUNTER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_timer |=> (count_ff == $past(io_wdata_i[11:0])) &&
                 (reload_latch_ff == $past(io_wdata_i[11:0])))
    else $error("timer write did not load latch and counter");

  AST_READ_SHOWS_COUNTER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (io_rd_i && data_hit && index_ff == mgmt_event_pkg::IDX_IDLE_TIMER)
    |=> io_rdata_o == {$past(prescale_sel_ff), 3'h0, $past(count_ff)})
    else $error("timer read did not return counter and prescale bit");

  AST_SLOW_TICK_WAITS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (prescale_sel_ff && tick_1024hz_i && prescaler_ff != 6'h00 &&
     !wr_timer && !reload_now) |=> $stable(count_ff))
    else $error("counter moved on a fast tick in slow mode");

  AST_FAST_TICK_COUNTS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!prescale_sel_ff && tick_1024hz_i && ctrl_ff.timer_count_enable &&
     count_ff != 12'h000 && !wr_timer && !reload_now)
    |=> count_ff == $past(count_ff) - 12'h001)
    else $error("counter missed a fast tick");

  AST_RELOAD_FROM_LATCH: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (reload_now && !wr_timer) |=> count_ff == $past(reload_latch_ff))
    else $error("counter was not reloaded from latch");

  AST_STOPS_AT_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (count_ff == 12'h000 && !wr_timer && !reload_now)
    |=> count_ff == 12'h000)
    else $error("counter left zero without reload");

  AST_NO_COUNT_WHEN_DISABLED: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_ff.timer_count_enable && !wr_timer && !reload_now)
    |=> $stable(count_ff))
    else $error("counter decremented without count enable");

  AST_PRESCALER_PRESET: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_timer |=> prescaler_ff == mgmt_event_pkg::PRESCALE_ONES)
    else $error("prescaler not preset by timer write");

  AST_EXTERNAL_SETS_FLAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ext_set |=> flags_ff.external_event_flag ##1 !mgmt_interrupt_output_n_o)
    else $error("external event did not raise flag and interrupt");

  AST_HALT_SETS_FLAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    halt_set |=> flags_ff.halt_state_flag)
    else $error("halt cycle did not set its flag");

  AST_EXPIRY_SETS_FLAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tim_set |=> flags_ff.timer_expired_flag && count_ff == 12'h000)
    else $error("timer expiry did not set its flag");

  AST_GLOBAL_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_ff.global_event_enable |=> mgmt_interrupt_output_n_o)
    else $error("interrupt asserted without global enable");

  AST_WRITE_ZERO_CLEARS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_event && !io_wdata_i[mgmt_event_pkg::B_TIM_FLAG] && !tim_set)
    |=> !flags_ff.timer_expired_flag)
    else $error("written zero did not clear timer flag");

  AST_WRITE_ONE_KEEPS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_event && io_wdata_i[mgmt_event_pkg::B_EXT_FLAG] && !ext_set)
    |=> $stable(flags_ff.external_event_flag))
    else $error("written one changed external flag");

  AST_PENDING_HOLDS_IRQ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.global_event_enable && (|flags_ff))
    |=> !mgmt_interrupt_output_n_o)
    else $error("interrupt dropped while a flag was pending");

  AST_LOW_REGION_STEER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_ff.low_region_map_enable && mgmt_mode_acknowledge_i &&
     in_low_region(mem_addr_i)) |=> low_region_dram_o)
    else $error("low region not steered to dram");

endmodule // mgmt_event_timer

// ### tb_smi_event_idle_timer.sv
// self-checking bench for the management event and idle timer block
// assumes mgmt_event_pkg and mgmt_cpu_model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module tb_smi_event_idle_timer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic [15:0] rdata;
  logic tick = 1'b0;
  logic ext_n = 1'b1;
  logic cs_act = 1'b0;
  logic halt = 1'b0;
  logic ack;
  logic irq_n;
  logic [19:0] mem_addr = 20'h00000;
  logic low_dram;
  logic top_allow;
  int n_fail = 0;
  int total_checks = 0;
  // ********************************************************
  // clock, design and processor model
  // ********************************************************
  always #2.5 clk_i = ~clk_i;
  mgmt_event_timer i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .tick_1024hz_i(tick), .external_event_input_n_i(ext_n),
    .chip_select_activity_i(cs_act), .halt_cycle_i(halt),
    .mgmt_mode_acknowledge_i(ack), .mgmt_interrupt_output_n_o(irq_n),
    .mem_addr_i(mem_addr), .low_region_dram_o(low_dram),
    .top_region_allow_o(top_allow));
  mgmt_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_n_i(irq_n),
    .ack_o(ack));
  // ********************************************************
  // port tasks
  // ********************************************************
  // index write, then one data-port write or read
  task automatic xfer(input logic [5:0] idx, input logic rd,
                      input logic [15:0] d);
    @(posedge clk_i);
    #1;
    io_addr = mgmt_event_pkg::INDEX_PORT_ADDR;
    io_wdata = {10'h000, idx};
    io_wr = 1'b1;
    @(posedge clk_i);
    #1;
    io_addr = mgmt_event_pkg::DATA_PORT_ADDR;
    io_wdata = d;
    io_wr = !rd;
    io_rd = rd;
    @(posedge clk_i);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    rdata = io_rdata;
  endtask
  task automatic wt(input logic [15:0] d);
    xfer(mgmt_event_pkg::IDX_IDLE_TIMER, 1'b0, d);
  endtask
  task automatic wc(input logic [15:0] d);
    xfer(mgmt_event_pkg::IDX_EVENT_CTRL, 1'b0, d);
  endtask
  task automatic rt();
    xfer(mgmt_event_pkg::IDX_IDLE_TIMER, 1'b1, 16'h0000);
  endtask
  task automatic rc();
    xfer(mgmt_event_pkg::IDX_EVENT_CTRL, 1'b1, 16'h0000);
  endtask
  // n one-cycle ticks, one every two clocks
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      tick = 1'b1;
      @(posedge clk_i);
      #1;
      tick = 1'b0;
    end
  endtask
  // one-cycle source pulse: 0 external, 1 chip select, 2 halt
  task automatic pulse(input logic [1:0] k);
    @(posedge clk_i);
    #1;
    ext_n = (k != 2'h0);
    cs_act = (k == 2'h1);
    halt = (k == 2'h2);
    @(posedge clk_i);
    #1;
    ext_n = 1'b1;
    cs_act = 1'b0;
    halt = 1'b0;
  endtask
  // flag one edge later, interrupt the edge after
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    `CHK(irq_n, 1'h1)
    `CHK(low_dram, 1'h0)
    `CHK(top_allow, 1'h1)
    rt();
    `CHK(rdata, 16'h0000)
    rc();
    `CHK(rdata, 16'h0000)
    xfer(6'h0d, 1'b1, 16'h0000);
    `CHK(rdata, 16'h0000)
    $display("done: reset");
  endtask
  task automatic t_timer();
    wt(16'h8123);
    rt();
    `CHK(rdata, 16'h8123)
    ticks(3);
    rt();
    `CHK(rdata, 16'h8123)
    wt(16'h0005);
    wc(16'h0004);
    ticks(2);
    rt();
    `CHK(rdata, 16'h0003)
    wt(16'h8005);
    ticks(63);
    rt();
    `CHK(rdata, 16'h8005)
    ticks(1);
    rt();
    `CHK(rdata, 16'h8004)
    $display("done: timer");
  endtask
  task automatic t_expiry();
    wt(16'h0002);
    wc(16'h0024);
    ticks(4);
    rt();
    `CHK(rdata, 16'h0000)
    `CHK(irq_n, 1'h0)
    rc();
    `CHK(rdata, 16'h0424)
    repeat (50) @(posedge clk_i);
    rt();
    `CHK(rdata, 16'h0002)
    wc(16'h0424);
    rc();
    `CHK(rdata, 16'h0424)
    wc(16'h0024);
    settle();
    `CHK(irq_n, 1'h1)
    wc(16'h0000);
    $display("done: expiry");
  endtask
  task automatic t_ext();
    wc(16'h0001);
    pulse(2'h0);
    settle();
    `CHK(irq_n, 1'h1)
    wc(16'h0021);
    pulse(2'h0);
    settle();
    `CHK(irq_n, 1'h0)
    rc();
    `CHK(rdata, 16'h0221)
    wc(16'h0021);
    settle();
    `CHK(irq_n, 1'h1)
    wc(16'h0000);
    $display("done: external");
  endtask
  task automatic t_reload();
    wt(16'h0010);
    wc(16'h0046);
    ticks(2);
    rt();
    `CHK(rdata, 16'h000e)
    pulse(2'h0);
    rt();
    `CHK(rdata, 16'h0010)
    ticks(3);
    pulse(2'h1);
    rt();
    `CHK(rdata, 16'h0010)
    wc(16'h0027);
    ticks(1);
    pulse(2'h0);
    settle();
    `CHK(irq_n, 1'h0)
    rt();
    `CHK(rdata, 16'h0010)
    wc(16'h0000);
    $display("done: reload");
  endtask
  task automatic t_halt();
    wc(16'h0028);
    pulse(2'h2);
    settle();
    `CHK(irq_n, 1'h0)
    rc();
    `CHK(rdata, 16'h1028)
    wc(16'h0000);
    settle();
    `CHK(irq_n, 1'h1)
    $display("done: halt");
  endtask
  task automatic t_swmap();
    mem_addr = 20'ha0000;
    wc(16'h01b0);
    settle();
    `CHK(irq_n, 1'h0)
    `CHK(top_allow, 1'h0)
    `CHK(low_dram, 1'h0)
    repeat (50) @(posedge clk_i);
    #1;
    `CHK(low_dram, 1'h1)
    `CHK(top_allow, 1'h1)
    mem_addr = 20'hc0000;
    settle();
    `CHK(low_dram, 1'h0)
    wc(16'h0180);
    settle();
    settle();
    `CHK(irq_n, 1'h1)
    `CHK(top_allow, 1'h0)
    wc(16'h0000);
    $display("done: software and remap");
  endtask
  // ********************************************************
  // verdict and run control
  // ********************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_timer();
    t_expiry();
    t_ext();
    t_reload();
    t_halt();
    t_swmap();
    end_sim();
  end
  // whole run is a few hundred cycles
  initial begin
    #100us;
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule // tb_smi_event_idle_timer
